// File: tcs_source_cc.sv
`timescale 1ns/1ps

module tcs_fifo #(
  parameter int unsigned WIDTH = 10,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             sys_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_r != AW'(0) + (AW+1)'(DEPTH)) ;
  assign out_valid_o = (count_r != '0);
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop)
      begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop)
      begin
        count_r <= count_r + (AW+1)'(1);
      end
      else if (pop && !push)
      begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end
endmodule

module tcs_source_cc
  import tcs_pkg::*;
#(
  parameter int unsigned ATTACH_DEB_CYC = (CLK_HZ / 1000000) * ATTACH_DEB_US
) (
  input  wire logic       sys_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       cc1_in_window_i,
  input  wire logic       cc2_in_window_i,
  input  wire logic       cc1_above_upper_i,
  input  wire logic       cc2_above_upper_i,
  input  wire logic       cc1_detach_i,
  input  wire logic       cc2_detach_i,
  input  wire logic       vbus_low_i,
  input  wire logic       supply_ready_i,
  input  wire logic       wake_i,
  input  wire logic       pd_capable_i,
  input  wire logic       hv_grant_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_last_i,
  input  wire logic       tx_drc_byte_i,
  input  wire logic       tx_valid_i,
  output logic            tx_ready_o,
  output logic [1:0]      cc1_pullup_sel_o,
  output logic [1:0]      cc2_pullup_sel_o,
  output logic            sleep_pullup_current_o,
  output logic            wake_cmp_en_o,
  output logic            vbus_en_o,
  output logic            vbus_5v_sel_o,
  output logic            vconn_cc1_en_o,
  output logic            vconn_cc2_en_o,
  output logic            attached_o,
  output logic            orient_cc2_o,
  output logic            cc1_tx_o,
  output logic            cc1_tx_oe_n_o,
  output logic            cc2_tx_o,
  output logic            cc2_tx_oe_n_o,
  output logic            transmit_bias_rail_o
);
  // three-stage synchronisers; a change counts once stages two and three agree
  logic [SYNC_N-1:0] raw;
  logic [SYNC_N-1:0] s1_r;
  logic [SYNC_N-1:0] s2_r;
  logic [SYNC_N-1:0] s3_r;
  logic [SYNC_N-1:0] in_r;
  assign raw = {supply_ready_i, vbus_low_i, cc2_detach_i, cc1_detach_i,
                cc2_above_upper_i, cc1_above_upper_i, cc2_in_window_i, cc1_in_window_i};

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      in_r <= '0;
    end
    else
    begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < SYNC_N; i++)
      begin
        if (s2_r[i] == s3_r[i])
        begin
          in_r[i] <= s3_r[i];
        end
      end
    end
  end

  logic wk1_r;
  logic wk2_r;
  logic wk3_r;
  logic wake_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      wk1_r  <= 1'b0;
      wk2_r  <= 1'b0;
      wk3_r  <= 1'b0;
      wake_r <= 1'b0;
    end
    else
    begin
      wk1_r <= wake_i;
      wk2_r <= wk1_r;
      wk3_r <= wk2_r;
      if (wk2_r == wk3_r)
      begin
        wake_r <= wk3_r;
      end
    end
  end

  logic win1, win2, up1, up2, det1, det2, vbus_low, sup_rdy;
  assign {sup_rdy, vbus_low, det2, det1, up2, up1, win2, win1} = in_r;

  tcs_state_t state_r;
  tcs_state_t state_nxt;
  logic       orient_r;
  logic [31:0] deb_cnt_r;
  logic       attach_cond;
  logic       sleep_cond;
  logic       deb_done;
  logic       mon_detach;
  logic       connected;

  assign attach_cond = (win1 ^ win2) && vbus_low;
  assign sleep_cond  = up1 && up2;
  assign deb_done    = (deb_cnt_r >= ATTACH_DEB_CYC - 1);
  assign mon_detach  = orient_r ? det2 : det1;
  assign connected   = (state_r == ST_VBUS_ON) || (state_r == ST_SRC_3A) ||
                       (state_r == ST_SRC_1A5);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_UNATT:
      begin
        if (attach_cond)
          state_nxt = ST_ATT_DEB;
        else if (sleep_cond)
          state_nxt = ST_SLP_DEB;
      end
      ST_ATT_DEB:
      begin
        if (!attach_cond || (win2 != orient_r))
          state_nxt = ST_UNATT;
        else if (deb_done)
          state_nxt = ST_VBUS_ON;
      end
      ST_SLP_DEB:
      begin
        if (!sleep_cond)
          state_nxt = ST_UNATT;
        else if (deb_done)
          state_nxt = ST_SLEEP;
      end
      ST_SLEEP:
      begin
        if (wake_r)
          state_nxt = ST_UNATT;
      end
      ST_VBUS_ON:
      begin
        if (mon_detach)
          state_nxt = ST_UNATT;
        else if (sup_rdy)
          state_nxt = ST_SRC_3A;
      end
      ST_SRC_3A:
      begin
        if (mon_detach)
          state_nxt = ST_UNATT;
        else if (pd_capable_i)
          state_nxt = ST_SRC_1A5;
      end
      ST_SRC_1A5:
      begin
        if (mon_detach)
          state_nxt = ST_UNATT;
      end
      default:
        state_nxt = ST_UNATT;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      state_r <= ST_UNATT;
    else
      state_r <= state_nxt;
  end

  // counter restarts on every state change, so a dropped condition restarts it
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      deb_cnt_r <= '0;
    else if (state_nxt != state_r || !(state_r == ST_ATT_DEB || state_r == ST_SLP_DEB))
      deb_cnt_r <= '0;
    else if (!deb_done)
      deb_cnt_r <= deb_cnt_r + 32'h1;
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      orient_r <= 1'b0;
    else if (state_r == ST_UNATT && attach_cond)
      orient_r <= win2;
  end

  // higher voltage only after a contract exists; 5 V is always applied first
  logic hv_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hv_r <= 1'b0;
    else
      hv_r <= (state_r == ST_SRC_1A5) && hv_grant_i;
  end

  logic [1:0] pu_active;
  always_comb
  begin
    pu_active = PU_OFF;
    if (state_r == ST_SRC_3A)
      pu_active = PU_3A;
    else if (state_r == ST_SRC_1A5)
      pu_active = PU_1A5;
  end

  logic pre_attach;
  assign pre_attach = (state_r == ST_UNATT) || (state_r == ST_ATT_DEB) ||
                      (state_r == ST_SLP_DEB);
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cc1_pullup_sel_o       <= PU_DEFAULT;
      cc2_pullup_sel_o       <= PU_DEFAULT;
      sleep_pullup_current_o <= 1'b0;
      wake_cmp_en_o          <= 1'b0;
      vbus_en_o              <= 1'b0;
      vbus_5v_sel_o          <= 1'b1;
      vconn_cc1_en_o         <= 1'b0;
      vconn_cc2_en_o         <= 1'b0;
      attached_o             <= 1'b0;
      orient_cc2_o           <= 1'b0;
    end
    else
    begin
      cc1_pullup_sel_o       <= pre_attach ? PU_DEFAULT : (orient_r ? PU_OFF : pu_active);
      cc2_pullup_sel_o       <= pre_attach ? PU_DEFAULT : (orient_r ? pu_active : PU_OFF);
      sleep_pullup_current_o <= (state_r == ST_SLEEP);
      wake_cmp_en_o          <= (state_r == ST_SLEEP);
      vbus_en_o              <= connected;
      vbus_5v_sel_o          <= !hv_r;
      vconn_cc1_en_o         <= (state_r == ST_SRC_3A || state_r == ST_SRC_1A5) && orient_r;
      vconn_cc2_en_o         <= (state_r == ST_SRC_3A || state_r == ST_SRC_1A5) && !orient_r;
      attached_o             <= connected;
      orient_cc2_o           <= orient_r;
    end
  end

  // transmit path: bytes queue in the fifo, the encoder drains them lsb first
  logic [FIFO_WIDTH-1:0] fifo_dout;
  logic                  fifo_valid;
  logic                  fifo_pop;
  tcs_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .arst_n_i    (arst_n_i),
    .in_data_i   ({tx_last_i, tx_drc_byte_i, tx_data_i}),
    .in_valid_i  (tx_valid_i),
    .in_ready_o  (tx_ready_o),
    .out_data_o  (fifo_dout),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop)
  );

  logic        busy_r;
  logic        line_r;
  logic [7:0]  sh_r;
  logic        last_r;
  logic [2:0]  bit_r;
  logic [15:0] ph_r;
  logic        tx_ok;
  logic        ui_end;
  logic        byte_end;
  logic [7:0]  load_byte;

  assign tx_ok     = (state_r == ST_SRC_3A) || (state_r == ST_SRC_1A5);
  assign ui_end    = busy_r && (ph_r == 16'(UI_CYC - 1));
  assign byte_end  = ui_end && (bit_r == 3'h7);
  // a capabilities byte carrying the data flag always has it set
  assign load_byte = fifo_dout[8] ? (fifo_dout[7:0] | (8'h1 << DRC_FLAG_POS))
                                  : fifo_dout[7:0];
  assign fifo_pop  = fifo_valid && ((!busy_r && tx_ok) || (byte_end && !last_r));

  // an underrun mid-message ends the frame rather than emitting garbage
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      busy_r <= 1'b0;
      line_r <= 1'b0;
      sh_r   <= '0;
      last_r <= 1'b0;
      bit_r  <= '0;
      ph_r   <= '0;
    end
    else if (!busy_r)
    begin
      ph_r  <= '0;
      bit_r <= '0;
      if (fifo_pop)
      begin
        busy_r <= 1'b1;
        sh_r   <= load_byte;
        last_r <= fifo_dout[9];
      end
    end
    else if (!tx_ok)
    begin
      busy_r <= 1'b0;
    end
    else
    begin
      ph_r <= ui_end ? 16'h0 : ph_r + 16'h1;
      if (ph_r == 16'(HALF_UI_CYC - 1) && sh_r[0])
        line_r <= !line_r;
      if (ui_end)
      begin
        line_r <= !line_r;
        sh_r   <= {1'b0, sh_r[7:1]};
        bit_r  <= bit_r + 3'h1;
      end
      if (byte_end)
      begin
        if (fifo_pop)
        begin
          sh_r   <= load_byte;
          last_r <= fifo_dout[9];
        end
        else
          busy_r <= 1'b0;
      end
    end
  end

  // the closing toggle of a frame is launched as busy drops; without one more
  // driven cycle that last edge would never reach the line
  logic hold_r;
  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      hold_r <= 1'b0;
    else
      hold_r <= byte_end && tx_ok && !fifo_pop;
  end

  assign cc1_tx_o             = line_r;
  assign cc2_tx_o             = line_r;
  assign cc1_tx_oe_n_o        = !((busy_r || hold_r) && !orient_r);
  assign cc2_tx_oe_n_o        = !((busy_r || hold_r) && orient_r);
  assign transmit_bias_rail_o = busy_r || hold_r;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  vbus_unattached_a: assert property (pre_attach |=> !vbus_en_o)
    else $error("vbus powered without confirmed attach");
  vconn_channel_a: assert property (!(vconn_cc1_en_o && !orient_cc2_o) &&
                                    !(vconn_cc2_en_o && orient_cc2_o))
    else $error("vconn applied to channel pin");
  vconn_ready_a: assert property ($rose(vconn_cc1_en_o || vconn_cc2_en_o) |->
                                  $past(sup_rdy, 2) && attached_o)
    else $error("vconn before supply ready");
  bias_rail_a: assert property ((transmit_bias_rail_o == !(cc1_tx_oe_n_o && cc2_tx_oe_n_o)) &&
                                (!$rose(transmit_bias_rail_o) || $past(fifo_pop && tx_ok)))
    else $error("bias rail not tied to transmission");
  ui_edge_a: assert property (ui_end && tx_ok |=> line_r != $past(line_r))
    else $error("no toggle at end of interval");
  mid_edge_a: assert property (busy_r && tx_ok && ph_r == 16'(HALF_UI_CYC - 1) |=>
                               (line_r != $past(line_r)) == $past(sh_r[0]))
    else $error("mid interval toggle wrong");
  detach_drop_a: assert property (connected && mon_detach |=> state_r == ST_UNATT ##1 !vbus_en_o)
    else $error("detach did not drop vbus");
  default_pullup_a: assert property (state_r == ST_UNATT |=> cc1_pullup_sel_o == PU_DEFAULT &&
                                     cc2_pullup_sel_o == PU_DEFAULT)
    else $error("default pullup missing");
  deb_restart_a: assert property (state_r == ST_ATT_DEB && !attach_cond |=> deb_cnt_r == 32'h0)
    else $error("debounce did not restart");
  pd_level_a: assert property (state_r == ST_SRC_1A5 && !mon_detach |=> (orient_cc2_o ?
                               cc2_pullup_sel_o : cc1_pullup_sel_o) == PU_1A5)
    else $error("pd sink not given 1.5 A level");
endmodule

// File: tcs_pkg.sv
// Notes on behaviour
// - with no valid connection, source the default pull-up current on both channel pins.
// - attach only when exactly one pin sits in the sink window, debounced, VBUS low.
// - remember which pin attached, treat it as channel wire, monitor only it.
// - after attach: VBUS on, default pull-up off, VCONN to other pin, then 3A level.
// - switch pull-up to the 1.5 A level once the sink proves Power Delivery capable.
// - monitored pin above detach threshold during sequence removes VBUS, restarts attach watch.
// - both pins above the upper sink threshold for full debounce enters sleep.
// - in sleep use the low-accuracy pull-up and low-accuracy wake comparator.
// - enable VCONN only after attach and after power supply reports ready.
// - VCONN goes to the non-channel pin, never to the active channel pin.
// - biphase coding toggles the line at the end of every unit interval.
// - a one adds a mid-interval toggle, a zero has none.
// - coded transmit overrides pull-up level while sending, line released afterwards.
// - transmit bias rail high only while a message is being sent.
// - data-communications-capable flag is forced to 1 in source capabilities.
// - offer and apply 5 V first, before any higher voltage is negotiated.
// - VBUS stays unpowered until attachment is confirmed on the channel pins.
package tcs_pkg;
  localparam int unsigned CLK_HZ            = 125000000;
  localparam int unsigned ATTACH_DEB_US     = 150;
  localparam int unsigned BMC_BIT_RATE_HZ   = 300000;
  localparam int unsigned UI_CYC            = CLK_HZ / BMC_BIT_RATE_HZ;
  localparam int unsigned HALF_UI_CYC       = UI_CYC / 2;
  localparam int unsigned FIFO_DEPTH        = 16;
  localparam int unsigned FIFO_WIDTH        = 10;
  localparam int unsigned DRC_FLAG_POS      = 1;
  localparam logic [1:0]  PU_OFF            = 2'h0;
  localparam logic [1:0]  PU_DEFAULT        = 2'h1;
  localparam logic [1:0]  PU_1A5            = 2'h2;
  localparam logic [1:0]  PU_3A             = 2'h3;
  localparam int unsigned SYNC_N            = 8;

  typedef enum logic [2:0] {
    ST_UNATT   = 3'h0,
    ST_ATT_DEB = 3'h1,
    ST_VBUS_ON = 3'h3,
    ST_SRC_3A  = 3'h2,
    ST_SRC_1A5 = 3'h6,
    ST_SLP_DEB = 3'h4,
    ST_SLEEP   = 3'h5
  } tcs_state_t;
endpackage

// File: tcs_sink_model.sv
`timescale 1ns/1ps

module tcs_sink_model
  import tcs_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       plugged_i,
  input  wire logic       orient_cc2_i,
  input  wire logic       both_win_i,
  input  wire logic       cc1_tx_i,
  input  wire logic       cc1_tx_oe_n_i,
  input  wire logic       cc2_tx_i,
  input  wire logic       cc2_tx_oe_n_i,
  output logic            cc1_in_window_o,
  output logic            cc2_in_window_o,
  output logic            cc1_above_upper_o,
  output logic            cc2_above_upper_o,
  output logic            cc1_detach_o,
  output logic            cc2_detach_o,
  output logic            wake_o,
  output logic [4:0]      rx_cnt_o
);
  logic [7:0]  rx_mem [16];
  logic [7:0]  shift_r;
  logic [2:0]  bit_r;
  logic [15:0] gap_r;
  logic        mid_r;
  logic        prev_r;
  logic        line;
  logic        oe_n;

  // unused pin reads as open, so it sits above the sink window
  assign cc1_in_window_o   = plugged_i && (both_win_i || !orient_cc2_i);
  assign cc2_in_window_o   = plugged_i && (both_win_i || orient_cc2_i);
  assign cc1_above_upper_o = !cc1_in_window_o;
  assign cc2_above_upper_o = !cc2_in_window_o;
  assign cc1_detach_o      = !cc1_in_window_o;
  assign cc2_detach_o      = !cc2_in_window_o;
  assign wake_o            = plugged_i;
  // only the wire of our own plug side is listened to
  assign line = orient_cc2_i ? cc2_tx_i : cc1_tx_i;
  assign oe_n = orient_cc2_i ? cc2_tx_oe_n_i : cc1_tx_oe_n_i;

  initial rx_cnt_o = '0;

  // an edge over three quarters of an interval after the last bit edge closes a bit;
  // a mid-interval edge leaves the interval timer running
  always @(posedge sys_clk_i)
  begin
    prev_r <= line;
    if (oe_n)
    begin
      gap_r <= '0;
      mid_r <= 1'b0;
      bit_r <= '0;
    end
    else if (line !== prev_r && gap_r + 1 > UI_CYC * 3 / 4)
    begin
      gap_r   <= '0;
      shift_r <= {mid_r, shift_r[7:1]};
      mid_r   <= 1'b0;
      bit_r   <= bit_r + 3'h1;
      if (bit_r == 3'h7)
      begin
        rx_mem[rx_cnt_o[3:0]] <= {mid_r, shift_r[7:1]};
        rx_cnt_o              <= rx_cnt_o + 5'h01;
      end
    end
    else
    begin
      gap_r <= gap_r + 16'h0001;
      if (line !== prev_r)
        mid_r <= 1'b1;
    end
  end
endmodule

// File: tcs_source_cc_tb.sv
`timescale 1ns/1ps

module tcs_source_cc_tb;
  import tcs_pkg::*;
  localparam int unsigned DEB = 20;
  logic       sys_clk, arst_n, vbus_low, supply_ready, pd_capable, hv_grant;
  logic       plugged, orient, both_win;
  logic [7:0] tx_data;
  logic       tx_last, tx_drc, tx_valid, tx_ready;
  logic       c1_win, c2_win, c1_up, c2_up, c1_det, c2_det, wake;
  logic [1:0] c1_pu, c2_pu;
  logic       slp_pu, wake_en, vbus_en, v5_sel, vc1, vc2, att, or2;
  logic       c1_tx, c1_oe_n, c2_tx, c2_oe_n, rail;
  logic [4:0] rx_cnt;
  int         failures, checked;

  tcs_source_cc #(.ATTACH_DEB_CYC(DEB)) u_tcs_source_cc (
    .sys_clk_i(sys_clk), .arst_n_i(arst_n), .cc1_in_window_i(c1_win),
    .cc2_in_window_i(c2_win), .cc1_above_upper_i(c1_up), .cc2_above_upper_i(c2_up),
    .cc1_detach_i(c1_det), .cc2_detach_i(c2_det), .vbus_low_i(vbus_low),
    .supply_ready_i(supply_ready), .wake_i(wake), .pd_capable_i(pd_capable),
    .hv_grant_i(hv_grant), .tx_data_i(tx_data), .tx_last_i(tx_last),
    .tx_drc_byte_i(tx_drc), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
    .cc1_pullup_sel_o(c1_pu), .cc2_pullup_sel_o(c2_pu), .sleep_pullup_current_o(slp_pu),
    .wake_cmp_en_o(wake_en), .vbus_en_o(vbus_en), .vbus_5v_sel_o(v5_sel),
    .vconn_cc1_en_o(vc1), .vconn_cc2_en_o(vc2), .attached_o(att), .orient_cc2_o(or2),
    .cc1_tx_o(c1_tx), .cc1_tx_oe_n_o(c1_oe_n), .cc2_tx_o(c2_tx),
    .cc2_tx_oe_n_o(c2_oe_n), .transmit_bias_rail_o(rail));

  tcs_sink_model u_tcs_sink_model (
    .sys_clk_i(sys_clk), .plugged_i(plugged), .orient_cc2_i(orient), .both_win_i(both_win),
    .cc1_tx_i(c1_tx), .cc1_tx_oe_n_i(c1_oe_n), .cc2_tx_i(c2_tx), .cc2_tx_oe_n_i(c2_oe_n),
    .cc1_in_window_o(c1_win), .cc2_in_window_o(c2_win), .cc1_above_upper_o(c1_up),
    .cc2_above_upper_o(c2_up), .cc1_detach_o(c1_det), .cc2_detach_o(c2_det),
    .wake_o(wake), .rx_cnt_o(rx_cnt));

  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic conclude();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  function automatic logic pick(int w);
    case (w)
      0: return vbus_en;
      1: return slp_pu;
      2: return vc1;
      3: return rail;
      4: return rx_cnt == 5'h10;
      default: return c2_pu == PU_1A5;
    endcase
  endfunction

  // a wait that expires is counted and ends the run
  task automatic wait_for(int w, logic v, int lim, string what);
    for (int i = 0; i < lim; i++)
    begin
      if (pick(w) === v)
        return;
      @(negedge sys_clk);
    end
    if (pick(w) === v)
      return;
    check(what, 8'(pick(w)), 8'(v));
    conclude();
  endtask

  function automatic logic [7:0] tx_byte(int i);
    return 8'h3c + 8'(i) * 8'h15;
  endfunction

  task automatic idle_no_attach();
    plugged  = 1'b1;
    both_win = 1'b1;
    repeat (60) @(negedge sys_clk);
    check("vbus both", vbus_en, 1'b0);
    both_win = 1'b0;
    vbus_low = 1'b0;
    repeat (60) @(negedge sys_clk);
    check("vbus high", vbus_en, 1'b0);
    plugged  = 1'b0;
    vbus_low = 1'b1;
    wait_for(1, 1'b1, 80, "sleep");
    check("wake cmp", wake_en, 1'b1);
    check("sleep vbus", vbus_en, 1'b0);
  endtask

  task automatic fill_fifo();
    for (int i = 0; i < FIFO_DEPTH; i++)
    begin
      tx_data  = tx_byte(i);
      tx_drc   = (i == 0);
      tx_last  = (i == FIFO_DEPTH - 1);
      tx_valid = 1'b1;
      // nothing drains yet, so ready must stand for each of the sixteen pushes
      check("fifo ready", tx_ready, 1'b1);
      @(negedge sys_clk);
    end
    tx_valid = 1'b0;
    check("fifo full", tx_ready, 1'b0);
  endtask

  task automatic attach_bounce();
    orient  = 1'b1;
    plugged = 1'b1;
    repeat (12) @(negedge sys_clk);
    plugged = 1'b0;
    repeat (3) @(negedge sys_clk);
    plugged = 1'b1;
    repeat (18) @(negedge sys_clk);
    check("vbus early", vbus_en, 1'b0);
    wait_for(0, 1'b1, 40, "attach");
    check("orient", or2, 1'b1);
    check("attached", att, 1'b1);
    check("pullup off", c2_pu, PU_OFF);
    check("vconn early", vc1, 1'b0);
    check("five volt", v5_sel, 1'b1);
    supply_ready = 1'b1;
    wait_for(2, 1'b1, 20, "vconn");
    check("vconn chan", vc2, 1'b0);
    check("pullup 3a", c2_pu, PU_3A);
  endtask

  task automatic transmit();
    wait_for(3, 1'b1, 20, "rail");
    check("oe chan", c2_oe_n, 1'b0);
    check("oe other", c1_oe_n, 1'b1);
    wait_for(4, 1'b1, 18 * 8 * UI_CYC, "rx count");
    for (int i = 0; i < FIFO_DEPTH; i++)
      check("rx byte", u_tcs_sink_model.rx_mem[i],
            tx_byte(i) | (i == 0 ? (8'h01 << DRC_FLAG_POS) : 8'h00));
    repeat (UI_CYC) @(negedge sys_clk);
    check("rail idle", rail, 1'b0);
    check("oe idle", c2_oe_n, 1'b1);
  endtask

  task automatic upgrade_detach();
    pd_capable = 1'b1;
    wait_for(5, 1'b1, 20, "1a5");
    hv_grant = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("hv grant", v5_sel, 1'b0);
    plugged  = 1'b0;
    wait_for(0, 1'b0, 20, "detach");
    repeat (2) @(negedge sys_clk);
    check("vconn off", vc1, 1'b0);
    check("default pu", c1_pu, PU_DEFAULT);
    check("five volt back", v5_sel, 1'b1);
  endtask

  initial
  begin
    {arst_n, vbus_low, supply_ready, pd_capable, hv_grant} = '0;
    {plugged, orient, both_win, tx_last, tx_drc, tx_valid} = '0;
    tx_data = '0;
    repeat (2) @(negedge sys_clk);
    check("rst pu1", c1_pu, PU_DEFAULT);
    check("rst pu2", c2_pu, PU_DEFAULT);
    check("rst vbus", vbus_en, 1'b0);
    check("rst rail", rail, 1'b0);
    check("rst oe", c2_oe_n, 1'b1);
    arst_n   = 1'b1;
    vbus_low = 1'b1;
    idle_no_attach();
    fill_fifo();
    attach_bounce();
    transmit();
    upgrade_detach();
    conclude();
  end
endmodule
